/* hdl/icv_defines.svh */
// constants for the indirect cv write and address select block
`ifndef ICV_DEFINES_SVH
`define ICV_DEFINES_SVH

// configuration variable numbers
`define ICV_CV_SHORT_ADDR 10'h001
`define ICV_CV_ACCEL 10'h003
`define ICV_CV_DECEL 10'h004
`define ICV_CV_LONG_HI 10'h011
`define ICV_CV_LONG_LO 10'h012
`define ICV_CV_CONFIG 10'h01d
`define ICV_CV_IND_ADDR_HUND 10'h060
`define ICV_CV_IND_ADDR_UT 10'h061
`define ICV_CV_IND_VAL_HUND 10'h062
`define ICV_CV_IND_VAL_TRIG 10'h063
`define ICV_CV_NONE 10'h000

// field positions and masks
`define ICV_CFG_LONG_BIT 5
`define ICV_LONG_HI_W 6
`define ICV_SHORT_W 7
`define ICV_RAMP_W 6
`define ICV_FN_BYPASS 4
`define ICV_FN_SHUNT 3

// value limits
`define ICV_HUND_MAX 8'h09
`define ICV_UT_MAX 8'h63
`define ICV_SHORT_MIN 8'h01
`define ICV_SHORT_MAX 8'h7f
`define ICV_RAMP_MAX 8'h3f
`define ICV_LONG_MIN 14'h0080
`define ICV_LONG_MAX 14'h27ff
`define ICV_VALUE_MAX 10'h0ff
`define ICV_HUNDRED 10'h064

// reset values
`define ICV_RST_SHORT 8'h03
`define ICV_RST_ACCEL 8'h00
`define ICV_RST_DECEL 8'h00
`define ICV_RST_LONG_HI 8'hc0
`define ICV_RST_LONG_LO 8'h80
`define ICV_RST_CFG 8'h06
`define ICV_RST_HELPER 8'h00

// timing: one ramp unit per cv count per speed step
`define ICV_CLK_NS 8
`define ICV_RAMP_UNIT_NS 1000000
`define ICV_RAMP_UNIT_CYC (`ICV_RAMP_UNIT_NS / `ICV_CLK_NS)

`endif

/* hdl/icv_pkg.sv */
// types shared by the indirect cv write and address select block
package icv_pkg;
  typedef logic [9:0] icv_num_t;
  typedef logic [7:0] icv_byte_t;
  typedef logic [13:0] icv_addr_t;
  typedef enum logic {
    ICV_ST_IDLE,
    ICV_ST_XFER
  } icv_state_t;
endpackage

/* hdl/icv_ramp_if.sv */
// interface between cv control and the speed ramp
`timescale 1ns/1ps
`default_nettype none
interface icv_ramp_if;
  logic [5:0] accel_cv;
  logic [5:0] decel_cv;
  logic bypass;
  logic shunt;
  logic [7:0] target;
  logic [7:0] speed;
  modport ctrl (
    output accel_cv,
    output decel_cv,
    output bypass,
    output shunt,
    output target,
    input speed
  );
  modport ramp (
    input accel_cv,
    input decel_cv,
    input bypass,
    input shunt,
    input target,
    output speed
  );
endinterface
`default_nettype wire

/* hdl/icv_cv_mem.sv */
// cv storage memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module icv_cv_mem (
  input wire logic clk_sys_i,
  input wire logic we_i,
  input wire icv_pkg::icv_num_t waddr_i,
  input wire icv_pkg::icv_byte_t wdata_i,
  input wire icv_pkg::icv_num_t raddr_i,
  output icv_pkg::icv_byte_t rdata_o
);
  import icv_pkg::*;
  // no reset on the array: contents are undefined until written
  icv_byte_t mem_q [0:1023];
  icv_byte_t rdata_q;

  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_q <= mem_q[raddr_i];
  end

  assign rdata_o = rdata_q;
endmodule
`default_nettype wire

/* hdl/icv_ramp.sv */
// speed ramp with acceleration, deceleration, bypass and shunting
`timescale 1ns/1ps
`default_nettype none
`include "icv_defines.svh"
module icv_ramp #(
  parameter int unsigned TICK_CYC = `ICV_RAMP_UNIT_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  icv_ramp_if.ramp rp
);
  import icv_pkg::*;
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);

  logic [TW-1:0] tick_q, tick_d;
  logic [5:0] step_q, step_d;
  logic [7:0] speed_q, speed_d;
  logic [7:0] eff_target;
  logic [5:0] rate;
  logic tick;
  logic rising;

  always_comb begin
    tick = (tick_q == TICK_LAST);
    tick_d = tick ? '0 : tick_q + 1'b1;
    // shunting halves the commanded speed
    eff_target = rp.shunt ? {1'b0, rp.target[7:1]} : rp.target;
    rising = (eff_target > speed_q);
    // each direction picks its own time setting
    rate = rising ? rp.accel_cv : rp.decel_cv;
    step_d = step_q;
    speed_d = speed_q;
    if (rp.bypass || (rate == 6'h00)) begin
      speed_d = eff_target;
      step_d = 6'h00;
    end else if (speed_q == eff_target) begin
      step_d = 6'h00;
    end else if (tick) begin
      // fixed time per step, so a ramp from high speed covers more track
      if (step_q + 6'h01 >= rate) begin
        step_d = 6'h00;
        speed_d = rising ? speed_q + 8'h01 : speed_q - 8'h01;
      end else begin
        step_d = step_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_q <= '0;
      step_q <= 6'h00;
      speed_q <= 8'h00;
    end else begin
      tick_q <= tick_d;
      step_q <= step_d;
      speed_q <= speed_d;
    end
  end

  assign rp.speed = speed_q;
endmodule
`default_nettype wire

/* hdl/icv_top.sv */
// cv store with indirect write helpers, address select and ramp control
`timescale 1ns/1ps
`default_nettype none
`include "icv_defines.svh"
// Summary of operation
// - helper 96 holds target hundreds, 0-9
// - helper 97 holds target units/tens, 0-99
// - writing helper 99 stores into target cv
// - helpers 96 to 99 clear after transfer
// - helper 98 holds value hundreds, 0-9
// - split mode: 99 is units/tens, triggers
// - cv 1 short address, 1 to 127
// - cv 29 bit 5 picks long address
// - long addresses 128 to 10239 supported
// - long address lives in cv 17/18
// - standard format answers only one address at once
// - alternate format uses cv 1 concurrently
// - cv 3 accel, cv 4 decel, 0-63
// - accel and decel set independently
// - ramp distance grows with speed
// - function f4 bypasses the ramp
// - function f3 shunting halves speed
module icv_top #(
  parameter int unsigned RAMP_TICK_CYC = `ICV_RAMP_UNIT_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic cv_wr_i,
  input wire logic cv_rd_i,
  input wire icv_pkg::icv_num_t cv_num_i,
  input wire icv_pkg::icv_byte_t cv_wdata_i,
  output icv_pkg::icv_byte_t cv_rdata_o,
  output logic cv_rvalid_o,
  output logic xfer_done_o,
  output logic xfer_drop_o,
  input wire logic pkt_valid_i,
  input wire logic pkt_alt_fmt_i,
  input wire logic pkt_long_i,
  input wire icv_pkg::icv_addr_t pkt_addr_i,
  output logic addr_match_o,
  output logic long_sel_o,
  output icv_pkg::icv_addr_t active_addr_o,
  input wire icv_pkg::icv_byte_t throttle_i,
  input wire logic [7:0] fn_i,
  output icv_pkg::icv_byte_t speed_o
);
  import icv_pkg::*;

  icv_ramp_if rif ();
  // state of the write path
  icv_state_t state_q, state_d;
  icv_byte_t short_q, short_d;
  icv_byte_t accel_q, accel_d;
  icv_byte_t decel_q, decel_d;
  icv_byte_t long_hi_q, long_hi_d;
  icv_byte_t long_lo_q, long_lo_d;
  icv_byte_t cfg_q, cfg_d;
  icv_byte_t h_ah_q, h_ah_d;
  icv_byte_t h_aut_q, h_aut_d;
  icv_byte_t h_vh_q, h_vh_d;
  logic split_q, split_d;
  icv_num_t xtgt_q, xtgt_d;
  icv_byte_t xval_q, xval_d;
  logic xok_q, xok_d;
  logic done_q, done_d;
  logic drop_q, drop_d;
  // internal write port shared by direct and indirect writes
  logic int_we, int_ok, host_wr;
  icv_num_t int_num, tgt_calc, val_calc;
  icv_byte_t int_data;
  // read path
  logic rd_pend_q, rd_pend_d;
  icv_num_t rd_num_q, rd_num_d;
  icv_byte_t rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  icv_byte_t mem_rdata;
  // address match path
  logic match_q, match_d;
  logic lsel_q, lsel_d;
  icv_addr_t act_q, act_d;
  icv_addr_t long_addr, short_addr;
  logic long_ok, short_ok;
  function automatic logic helper_num(input icv_num_t n);
    helper_num = (n == `ICV_CV_IND_ADDR_HUND) || (n == `ICV_CV_IND_ADDR_UT) ||
                 (n == `ICV_CV_IND_VAL_HUND) || (n == `ICV_CV_IND_VAL_TRIG);
  endfunction
  // value checks applied to any write of a shadowed cv
  function automatic logic value_ok(input icv_num_t n, input icv_byte_t v);
    value_ok = 1'b1;
    case (n)
      `ICV_CV_SHORT_ADDR:
        value_ok = (v >= `ICV_SHORT_MIN) && (v <= `ICV_SHORT_MAX);
      `ICV_CV_ACCEL, `ICV_CV_DECEL: value_ok = (v <= `ICV_RAMP_MAX);
      default: value_ok = 1'b1;
    endcase
  endfunction
  // host writes are not taken while a transfer commits
  assign host_wr = cv_wr_i && (state_q == ICV_ST_IDLE);
  always_comb begin
    tgt_calc = {6'h00, h_ah_q[3:0]} * `ICV_HUNDRED + {2'b00, h_aut_q};
    val_calc = split_q ?
               {6'h00, h_vh_q[3:0]} * `ICV_HUNDRED + {2'b00, cv_wdata_i} :
               {2'b00, cv_wdata_i};
  end
  always_comb begin
    if (state_q == ICV_ST_XFER) begin
      int_we = xok_q;
      int_num = xtgt_q;
      int_data = xval_q;
    end else begin
      int_we = host_wr && !helper_num(cv_num_i);
      int_num = cv_num_i;
      int_data = cv_wdata_i;
    end
    int_ok = int_we && value_ok(int_num, int_data);
  end

  always_comb begin
    state_d = state_q;
    short_d = short_q;
    accel_d = accel_q;
    decel_d = decel_q;
    long_hi_d = long_hi_q;
    long_lo_d = long_lo_q;
    cfg_d = cfg_q;
    h_ah_d = h_ah_q;
    h_aut_d = h_aut_q;
    h_vh_d = h_vh_q;
    split_d = split_q;
    xtgt_d = xtgt_q;
    xval_d = xval_q;
    xok_d = xok_q;
    done_d = 1'b0;
    drop_d = 1'b0;
    if (int_ok) begin
      case (int_num)
        `ICV_CV_SHORT_ADDR: short_d = int_data;
        `ICV_CV_ACCEL: accel_d = int_data;
        `ICV_CV_DECEL: decel_d = int_data;
        `ICV_CV_LONG_HI: long_hi_d = int_data;
        `ICV_CV_LONG_LO: long_lo_d = int_data;
        `ICV_CV_CONFIG: cfg_d = int_data;
        default: ;
      endcase
    end
    case (state_q)
      ICV_ST_IDLE: begin
        if (host_wr) begin
          case (cv_num_i)
            `ICV_CV_IND_ADDR_HUND: begin
              if (cv_wdata_i <= `ICV_HUND_MAX) begin
                h_ah_d = cv_wdata_i;
              end
            end
            `ICV_CV_IND_ADDR_UT: begin
              if (cv_wdata_i <= `ICV_UT_MAX) begin
                h_aut_d = cv_wdata_i;
              end
            end
            `ICV_CV_IND_VAL_HUND: begin
              if (cv_wdata_i <= `ICV_HUND_MAX) begin
                h_vh_d = cv_wdata_i;
                split_d = 1'b1;
              end
            end
            `ICV_CV_IND_VAL_TRIG: begin
              // the value goes to the target, never kept in helper 99
              xtgt_d = tgt_calc;
              xval_d = val_calc[7:0];
              // a target of zero or a helper number is not implemented
              xok_d = (val_calc <= `ICV_VALUE_MAX) &&
                      (tgt_calc != `ICV_CV_NONE) && !helper_num(tgt_calc) &&
                      !(split_q && (cv_wdata_i > `ICV_UT_MAX));
              state_d = ICV_ST_XFER;
            end
            default: ;
          endcase
        end
      end
      ICV_ST_XFER: begin
        // commit happens through the shared write port this cycle
        h_ah_d = `ICV_RST_HELPER;
        h_aut_d = `ICV_RST_HELPER;
        h_vh_d = `ICV_RST_HELPER;
        split_d = 1'b0;
        done_d = xok_q && value_ok(xtgt_q, xval_q);
        drop_d = !done_d;
        state_d = ICV_ST_IDLE;
      end
      default: begin
        state_d = ICV_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ICV_ST_IDLE;
      short_q <= `ICV_RST_SHORT;
      accel_q <= `ICV_RST_ACCEL;
      decel_q <= `ICV_RST_DECEL;
      long_hi_q <= `ICV_RST_LONG_HI;
      long_lo_q <= `ICV_RST_LONG_LO;
      cfg_q <= `ICV_RST_CFG;
      h_ah_q <= `ICV_RST_HELPER;
      h_aut_q <= `ICV_RST_HELPER;
      h_vh_q <= `ICV_RST_HELPER;
      split_q <= 1'b0;
      xtgt_q <= `ICV_CV_NONE;
      xval_q <= 8'h00;
      xok_q <= 1'b0;
      done_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      short_q <= short_d;
      accel_q <= accel_d;
      decel_q <= decel_d;
      long_hi_q <= long_hi_d;
      long_lo_q <= long_lo_d;
      cfg_q <= cfg_d;
      h_ah_q <= h_ah_d;
      h_aut_q <= h_aut_d;
      h_vh_q <= h_vh_d;
      split_q <= split_d;
      xtgt_q <= xtgt_d;
      xval_q <= xval_d;
      xok_q <= xok_d;
      done_q <= done_d;
      drop_q <= drop_d;
    end
  end
  icv_cv_mem u_mem (
    .clk_sys_i(clk_sys_i),
    .we_i(int_ok),
    .waddr_i(int_num),
    .wdata_i(int_data),
    .raddr_i(cv_num_i),
    .rdata_o(mem_rdata)
  );
  // reads: shadowed cvs and helpers 96 to 98 come from registers, helper 99 reads as zero, others from memory
  always_comb begin
    rd_pend_d = cv_rd_i;
    rd_num_d = cv_num_i;
    rvalid_d = rd_pend_q;
    rdata_d = rdata_q;
    if (rd_pend_q) begin
      case (rd_num_q)
        `ICV_CV_SHORT_ADDR: rdata_d = short_q;
        `ICV_CV_ACCEL: rdata_d = accel_q;
        `ICV_CV_DECEL: rdata_d = decel_q;
        `ICV_CV_LONG_HI: rdata_d = long_hi_q;
        `ICV_CV_LONG_LO: rdata_d = long_lo_q;
        `ICV_CV_CONFIG: rdata_d = cfg_q;
        `ICV_CV_IND_ADDR_HUND: rdata_d = h_ah_q;
        `ICV_CV_IND_ADDR_UT: rdata_d = h_aut_q;
        `ICV_CV_IND_VAL_HUND: rdata_d = h_vh_q;
        `ICV_CV_IND_VAL_TRIG: rdata_d = `ICV_RST_HELPER;
        default: rdata_d = mem_rdata;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_pend_q <= 1'b0;
      rd_num_q <= `ICV_CV_NONE;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rd_pend_q <= rd_pend_d;
      rd_num_q <= rd_num_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end
  // address selection and packet match
  always_comb begin
    long_addr = {long_hi_q[`ICV_LONG_HI_W-1:0], long_lo_q};
    short_addr = {7'h00, short_q[`ICV_SHORT_W-1:0]};
    long_ok = (long_addr >= `ICV_LONG_MIN) && (long_addr <= `ICV_LONG_MAX);
    short_ok = (short_q != 8'h00);
    lsel_d = cfg_q[`ICV_CFG_LONG_BIT];
    act_d = lsel_d ? long_addr : short_addr;
    match_d = 1'b0;
    if (pkt_valid_i) begin
      if (pkt_alt_fmt_i) begin
        // alternate format always answers cv 1, whatever cv 29 says
        match_d = short_ok && (pkt_addr_i == short_addr);
      end else if (lsel_d) begin
        match_d = pkt_long_i && long_ok && (pkt_addr_i == long_addr);
      end else begin
        match_d = !pkt_long_i && short_ok && (pkt_addr_i == short_addr);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_q <= 1'b0;
      lsel_q <= 1'b0;
      act_q <= 14'h0000;
    end else begin
      match_q <= match_d;
      lsel_q <= lsel_d;
      act_q <= act_d;
    end
  end
  // ramp control
  assign rif.accel_cv = accel_q[`ICV_RAMP_W-1:0];
  assign rif.decel_cv = decel_q[`ICV_RAMP_W-1:0];
  assign rif.bypass = fn_i[`ICV_FN_BYPASS];
  assign rif.shunt = fn_i[`ICV_FN_SHUNT];
  assign rif.target = throttle_i;

  icv_ramp #(
    .TICK_CYC(RAMP_TICK_CYC)
  ) u_ramp (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .rp(rif)
  );

  assign cv_rdata_o = rdata_q;
  assign cv_rvalid_o = rvalid_q;
  assign xfer_done_o = done_q;
  assign xfer_drop_o = drop_q;
  assign addr_match_o = match_q;
  assign long_sel_o = lsel_q;
  assign active_addr_o = act_q;
  assign speed_o = rif.speed;
endmodule
`default_nettype wire

/* testbench/icv_top_assertions.sv */
// port assertions for the indirect cv write and address select block
`timescale 1ns/1ps
`default_nettype none
`include "icv_defines.svh"
module icv_top_checker (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic cv_wr_i,
  input wire logic cv_rd_i,
  input wire icv_pkg::icv_num_t cv_num_i,
  input wire logic cv_rvalid_o,
  input wire logic xfer_done_o,
  input wire logic xfer_drop_o,
  input wire logic pkt_valid_i,
  input wire logic pkt_alt_fmt_i,
  input wire logic pkt_long_i,
  input wire icv_pkg::icv_addr_t pkt_addr_i,
  input wire logic addr_match_o,
  input wire logic long_sel_o,
  input wire icv_pkg::icv_addr_t active_addr_o,
  input wire icv_pkg::icv_byte_t throttle_i,
  input wire logic [7:0] fn_i,
  input wire icv_pkg::icv_byte_t speed_o
);
  import icv_pkg::*;
  logic trig_w;
  logic std_w;
  logic long_ok_w;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  assign trig_w = cv_wr_i && (cv_num_i == `ICV_CV_IND_VAL_TRIG);
  assign std_w = pkt_valid_i && !pkt_alt_fmt_i;
  assign long_ok_w = (active_addr_o >= `ICV_LONG_MIN)
    && (active_addr_o <= `ICV_LONG_MAX);
  // a trigger in the commit cycle is ignored, so it starts nothing
  sequence trig_s;
    trig_w && !$past(trig_w);
  endsequence
  sequence steady_s;
    (fn_i[4] && $stable(throttle_i) && $stable(fn_i[3]))[*3];
  endsequence
  AST_RD_ANSWER: assert property (cv_rd_i |-> ##2 cv_rvalid_o)
    else $error("read answer missing");
  AST_XFER_RESULT: assert property (trig_s |-> ##2 (xfer_done_o ^ xfer_drop_o))
    else $error("trigger write without one result");
  AST_XFER_CAUSE: assert property ((xfer_done_o || xfer_drop_o) |-> $past(trig_w, 2))
    else $error("transfer result without trigger");
  AST_SHORT_HIT: assert property (std_w && !pkt_long_i && !long_sel_o && pkt_addr_i == active_addr_o && active_addr_o != '0 |=> addr_match_o)
    else $error("short address not matched");
  AST_LONG_HIT: assert property (std_w && pkt_long_i && long_sel_o && pkt_addr_i == active_addr_o && long_ok_w |=> addr_match_o)
    else $error("long address not matched");
  AST_ONE_ADDR: assert property (std_w && (pkt_long_i != long_sel_o) |=> !addr_match_o)
    else $error("unselected address kind matched");
  AST_LONG_RANGE: assert property (std_w && pkt_long_i && (pkt_addr_i < `ICV_LONG_MIN || pkt_addr_i > `ICV_LONG_MAX) |=> !addr_match_o)
    else $error("long address out of range matched");
  AST_MATCH_CAUSE: assert property (addr_match_o |-> $past(pkt_valid_i))
    else $error("match without packet");
  AST_BYPASS: assert property (steady_s |-> speed_o == (fn_i[3] ? throttle_i >> 1 : throttle_i))
    else $error("bypass speed wrong");
endmodule
bind icv_top icv_top_checker u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .cv_wr_i(cv_wr_i), .cv_rd_i(cv_rd_i), .cv_num_i(cv_num_i),
  .cv_rvalid_o(cv_rvalid_o), .xfer_done_o(xfer_done_o),
  .xfer_drop_o(xfer_drop_o), .pkt_valid_i(pkt_valid_i),
  .pkt_alt_fmt_i(pkt_alt_fmt_i), .pkt_long_i(pkt_long_i),
  .pkt_addr_i(pkt_addr_i), .addr_match_o(addr_match_o),
  .long_sel_o(long_sel_o), .active_addr_o(active_addr_o),
  .throttle_i(throttle_i), .fn_i(fn_i), .speed_o(speed_o));
`default_nettype wire

/* testbench/icv_station_model.sv */
// command station model issuing cv reads and writes
`timescale 1ns/1ps
`default_nettype none
`include "icv_defines.svh"
module icv_station_model (
  input wire logic clk_sys_i,
  input wire logic cv_rvalid_i,
  input wire icv_pkg::icv_byte_t cv_rdata_i,
  output logic cv_wr_o,
  output logic cv_rd_o,
  output icv_pkg::icv_num_t cv_num_o,
  output icv_pkg::icv_byte_t cv_wdata_o
);
  import icv_pkg::*;
  int slow = 0;
  initial begin
    cv_wr_o = 1'b0;
    cv_rd_o = 1'b0;
    cv_num_o = 10'h2aa;
    cv_wdata_o = 8'h55;
  end
  // released lines flip so a stale value never looks valid
  task automatic drop_lines();
    cv_num_o = ~cv_num_o;
    cv_wdata_o = ~cv_wdata_o;
  endtask
  task automatic wr(input icv_num_t n, input icv_byte_t d);
    repeat (slow + 1) @(posedge clk_sys_i);
    #1;
    cv_wr_o = 1'b1;
    cv_num_o = n;
    cv_wdata_o = d;
    @(posedge clk_sys_i) #1;
    cv_wr_o = 1'b0;
    drop_lines();
  endtask
  task automatic rd(input icv_num_t n, output icv_byte_t d, output bit ok);
    ok = 1'b0;
    d = '0;
    @(posedge clk_sys_i) #1;
    cv_rd_o = 1'b1;
    cv_num_o = n;
    @(posedge clk_sys_i) #1;
    cv_rd_o = 1'b0;
    drop_lines();
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk_sys_i) #1;
      if (cv_rvalid_i === 1'b1) begin
        ok = 1'b1;
        d = cv_rdata_i;
      end
    end
  endtask
  // address helpers first, value helper last
  task automatic ind(input int t, input int v, input bit split);
    wr(`ICV_CV_IND_ADDR_HUND, 8'(t / 100));
    wr(`ICV_CV_IND_ADDR_UT, 8'(t % 100));
    if (split) wr(`ICV_CV_IND_VAL_HUND, 8'(v / 100));
    wr(`ICV_CV_IND_VAL_TRIG, 8'(split ? v % 100 : v));
  endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the indirect cv block
`timescale 1ns/1ps
`default_nettype none
`include "icv_defines.svh"
module tb;
  import icv_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic pv = 1'b0, palt = 1'b0, plong = 1'b0;
  icv_addr_t paddr = '0;
  icv_byte_t thr = '0;
  logic [7:0] fn = '0;
  logic wr, rd, rv, done, drop, match, lsel;
  icv_num_t num;
  icv_byte_t wd, rdat, spd;
  icv_addr_t aaddr;
  int errors = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h4d07;
  always #4 clk_sys_i = ~clk_sys_i;
  icv_top #(.RAMP_TICK_CYC(4)) u_dut (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .cv_wr_i(wr), .cv_rd_i(rd), .cv_num_i(num),
    .cv_wdata_i(wd), .cv_rdata_o(rdat), .cv_rvalid_o(rv),
    .xfer_done_o(done), .xfer_drop_o(drop), .pkt_valid_i(pv),
    .pkt_alt_fmt_i(palt), .pkt_long_i(plong), .pkt_addr_i(paddr),
    .addr_match_o(match), .long_sel_o(lsel), .active_addr_o(aaddr),
    .throttle_i(thr), .fn_i(fn), .speed_o(spd));
  icv_station_model u_stn (.clk_sys_i(clk_sys_i), .cv_rvalid_i(rv),
    .cv_rdata_i(rdat), .cv_wr_o(wr), .cv_rd_o(rd), .cv_num_o(num),
    .cv_wdata_o(wd));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input icv_num_t n, input icv_byte_t exp);
    icv_byte_t d;
    bit ok;
    u_stn.rd(n, d, ok);
    if (!ok) begin
      errors++;
      end_sim();
    end
    chk(d, exp);
  endtask
  task automatic ind(input int t, input int v, input bit sp, input bit ok);
    int i;
    u_stn.ind(t, v, sp);
    for (i = 0; i < 4 && !(done || drop); i++) @(posedge clk_sys_i) #1;
    if (i == 4) begin
      errors++;
      end_sim();
    end
    chk({done, drop}, {ok, !ok});
    if (ok) rchk(10'(t), 8'(v));
    rchk(`ICV_CV_IND_ADDR_HUND, 8'h00);
    rchk(`ICV_CV_IND_ADDR_UT, 8'h00);
    rchk(`ICV_CV_IND_VAL_HUND, 8'h00);
    rchk(`ICV_CV_IND_VAL_TRIG, 8'h00);
  endtask
  task automatic pkt(input logic a, input logic l, input int ad, input logic e);
    @(posedge clk_sys_i) #1;
    pv = 1'b1;
    palt = a;
    plong = l;
    paddr = 14'(ad);
    @(posedge clk_sys_i) #1;
    pv = 1'b0;
    paddr = ~paddr;
    chk(match, e);
  endtask
  initial begin
    int t, v;
    repeat (20) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 chk(aaddr, 14'h0003);
    chk(lsel, 1'b0);
    ind(317, 120, 1'b1, 1'b1);
    ind(317, 77, 1'b0, 1'b1);
    for (int k = 0; k < 6; k++) begin
      t = 100 + int'(rnd() % 900);
      v = int'(rnd() % 256);
      u_stn.slow = k % 3;
      ind(t, v, k[0], 1'b1);
    end
    u_stn.slow = 0;
    ind(500, 260, 1'b1, 1'b0);
    ind(97, 5, 1'b0, 1'b0);
    ind(3, 2, 1'b0, 1'b1);
    ind(4, 70, 1'b0, 1'b0);
    u_stn.wr(`ICV_CV_IND_ADDR_HUND, 8'h0a);
    rchk(`ICV_CV_IND_ADDR_HUND, 8'h00);
    u_stn.wr(`ICV_CV_IND_ADDR_UT, 8'h64);
    rchk(`ICV_CV_IND_ADDR_UT, 8'h00);
    u_stn.wr(`ICV_CV_IND_ADDR_UT, 8'h63);
    rchk(`ICV_CV_IND_ADDR_UT, 8'h63);
    u_stn.wr(`ICV_CV_IND_VAL_HUND, 8'h0a);
    rchk(`ICV_CV_IND_VAL_HUND, 8'h00);
    $display("test indirect done");
    u_stn.wr(`ICV_CV_SHORT_ADDR, 8'h05);
    u_stn.wr(`ICV_CV_SHORT_ADDR, 8'h00);
    rchk(`ICV_CV_SHORT_ADDR, 8'h05);
    pkt(1'b0, 1'b0, 5, 1'b1);
    pkt(1'b0, 1'b0, 6, 1'b0);
    u_stn.wr(`ICV_CV_LONG_HI, 8'hc3);
    u_stn.wr(`ICV_CV_LONG_LO, 8'he8);
    u_stn.wr(`ICV_CV_CONFIG, 8'h26);
    repeat (2) @(posedge clk_sys_i);
    #1 chk(lsel, 1'b1);
    chk(aaddr, 14'd1000);
    pkt(1'b0, 1'b1, 1000, 1'b1);
    pkt(1'b0, 1'b0, 5, 1'b0);
    pkt(1'b1, 1'b0, 5, 1'b1);
    u_stn.wr(`ICV_CV_LONG_HI, 8'hc0);
    u_stn.wr(`ICV_CV_LONG_LO, 8'h64);
    pkt(1'b0, 1'b1, 100, 1'b0);
    u_stn.wr(`ICV_CV_CONFIG, 8'h06);
    $display("test address done");
    u_stn.wr(`ICV_CV_ACCEL, 8'h01);
    u_stn.wr(`ICV_CV_DECEL, 8'h00);
    @(posedge clk_sys_i) #1;
    thr = 8'd20;
    repeat (4) @(posedge clk_sys_i);
    #1 chk(spd < 8'd20, 1'b1);
    repeat (100) @(posedge clk_sys_i);
    #1 chk(spd, 8'd20);
    thr = 8'd0;
    repeat (3) @(posedge clk_sys_i);
    #1 chk(spd, 8'd0);
    fn = 8'h18;
    thr = 8'd200;
    repeat (4) @(posedge clk_sys_i);
    #1 chk(spd, 8'd100);
    fn = 8'h10;
    repeat (4) @(posedge clk_sys_i);
    #1 chk(spd, 8'd200);
    $display("test ramp done");
    end_sim();
  end
endmodule
`default_nettype wire
